// file: core/prg_defines.vh
// Constants for the physical random generator with health gate.
// Assumes inclusion by core/prg_health_gate.v only, clocked at 10 MHz.
//
// Contract
// RULE_01: Total-failure check on the source catches complete entropy loss at once.
// RULE_02: After a total failure is detected, no random words are delivered.
// RULE_03: Words depending on raw bits after a failure are withheld.
// RULE_04: Online statistical check runs right after start and throughout operation.
// RULE_05: Output stays blocked until the start-up online check has passed.
// RULE_06: Any online check defect stops delivery of random words.
// RULE_07: Online check scans the raw stream continuously, flags weakness within one window.
// RULE_08: Words are delivered as either eight or sixteen bits.
// RULE_09: Average entropy per internal bit exceeds 0.997; source design must assure it.
// RULE_10: Standard test suite cannot tell internal numbers from an ideal generator.
// RULE_11: A continuous generator test runs on every produced output block.
// RULE_12: User selects quality class by configuration; generator honours the selection.
// RULE_13: Hybrid class stays blocked until post-processing seeded; output rate never exceeds input.
// RULE_14: Each new output block is compared with the previous; equality raises failure.
`ifndef PRG_DEFINES_VH
`define PRG_DEFINES_VH

// Register byte addresses
`define PRG_ADDR_CTRL 12'h000
`define PRG_ADDR_STATUS 12'h004
`define PRG_ADDR_DATA 12'h008

// Control register fields
`define PRG_CTRL_EN 0
`define PRG_CTRL_W16 1
`define PRG_CTRL_HYBRID 2
`define PRG_CTRL_SEEDED 3
`define PRG_CTRL_RESTART 4
`define PRG_CTRL_RESET 4'h0

// Status register fields
`define PRG_ST_GATE 0
`define PRG_ST_TOTAL 1
`define PRG_ST_ONLINE 2
`define PRG_ST_CONT 3
`define PRG_ST_STATE_LO 4
`define PRG_ST_COUNT_LO 8

// Health test limits
`define PRG_RUN_LIMIT 6'h20
`define PRG_WIN_LAST 10'h3FF
`define PRG_ONES_LO 11'h19A
`define PRG_ONES_HI 11'h266

// Word widths
`define PRG_WORD_W 16
`define PRG_BITS_8 5'h08
`define PRG_BITS_16 5'h10

// Output buffer shape
`define PRG_FIFO_DEPTH 32
`define PRG_FIFO_AW 5

`endif

// file: core/prg_health_gate.v
// Physical random generator: health tests, output gate, word buffer, APB slave.
// Assumes a raw entropy bit sampled synchronously each clock and an APB master.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "prg_defines.vh"

module prg_fifo #(
   parameter W = 16,
   parameter D = 32,
   parameter AW = 5
) (
   input wire i_clk_sys,
   input wire i_nrst,
   input wire i_flush,
   input wire i_in_valid,
   output wire o_in_ready,
   input wire [W-1:0] i_in_data,
   output wire o_out_valid,
   input wire i_out_ready,
   output wire [W-1:0] o_out_data,
   output wire [AW:0] o_count
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;

   assign o_in_ready = (count != D[AW:0]);
   assign o_out_valid = (count != {(AW+1){1'b0}});
   assign o_out_data = mem[rd_ptr];
   assign o_count = count;
   assign push = i_in_valid && o_in_ready;
   assign pop = i_out_ready && o_out_valid;

   always @(posedge i_clk_sys)
   begin
      if (push)
         mem[wr_ptr] <= i_in_data;
   end

   always @(posedge i_clk_sys)
   begin
      if (!i_nrst || i_flush)
      begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr <= wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= rd_ptr + 1'b1;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule // prg_fifo

module prg_health_gate (
   input wire i_clk_sys,
   input wire i_nrst,
   input wire i_raw_bit,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   output reg o_gate_open
);
   localparam ST_IDLE = 2'b00;
   localparam ST_START = 2'b01;
   localparam ST_RUN = 2'b10;
   localparam ST_FAIL = 2'b11;

   reg [1:0] state;
   reg [3:0] ctrl;
   reg fl_total;
   reg fl_online;
   reg fl_cont;
   reg last_bit;
   reg [5:0] run_len;
   reg [9:0] win_cnt;
   reg [10:0] ones;
   reg [15:0] shreg;
   reg [4:0] bit_cnt;
   reg hold;
   reg [15:0] word;
   reg [15:0] prev_block;
   reg prev_valid;
   reg rd_ok;

   wire active;
   wire enable;
   wire restart;
   wire apb_setup;
   wire apb_done;
   wire [10:0] ones_next;
   wire win_end;
   wire win_pass;
   wire total_ev;
   wire online_ev;
   wire [4:0] word_bits;
   wire blk_done;
   wire [15:0] blk_next;
   wire cont_ev;
   wire any_fail;
   wire gate_now;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [15:0] fifo_out_data;
   wire [5:0] fifo_count;
   wire fifo_flush;
   wire fifo_pop;

   assign apb_setup = i_psel && !i_penable;
   assign apb_done = i_psel && i_penable && o_pready;
   assign restart = apb_done && i_pwrite && (i_paddr == `PRG_ADDR_CTRL)
      && i_pwdata[`PRG_CTRL_RESTART];
   assign enable = ctrl[`PRG_CTRL_EN];
   assign active = (state == ST_START) || (state == ST_RUN);

   // Repetition count on raw bits: a stuck source shows as a long run
   assign total_ev = active && (i_raw_bit == last_bit)
      && (run_len == `PRG_RUN_LIMIT - 6'h01); // RULE_01

   // Ones count over a fixed window, evaluated at every window end
   assign ones_next = ones + {10'h000, i_raw_bit};
   assign win_end = active && (win_cnt == `PRG_WIN_LAST); // RULE_07
   assign win_pass = (ones_next >= `PRG_ONES_LO) && (ones_next <= `PRG_ONES_HI);
   assign online_ev = win_end && !win_pass; // RULE_04

   // Block assembly; width follows the configured word size
   assign word_bits = ctrl[`PRG_CTRL_W16] ? `PRG_BITS_16 : `PRG_BITS_8; // RULE_08 RULE_12
   assign blk_done = active && !hold && (bit_cnt == word_bits - 5'h01);
   assign blk_next = ctrl[`PRG_CTRL_W16] ? {shreg[14:0], i_raw_bit}
      : {8'h00, shreg[6:0], i_raw_bit};
   assign cont_ev = blk_done && prev_valid && (blk_next == prev_block); // RULE_11 RULE_14

   assign any_fail = total_ev || online_ev || cont_ev;

   // Hybrid class needs the post-processing seed before anything leaves
   assign gate_now = (state == ST_RUN) && !any_fail
      && (!ctrl[`PRG_CTRL_HYBRID] || ctrl[`PRG_CTRL_SEEDED]); // RULE_05 RULE_13

   // Discard buffered words on any failure, on a restart or outside the run state: they may hold bad bits
   assign fifo_flush = any_fail || (state != ST_RUN) || restart; // RULE_03
   assign fifo_pop = apb_done && !i_pwrite && (i_paddr == `PRG_ADDR_DATA) && rd_ok;

   prg_fifo #(
      .W(`PRG_WORD_W),
      .D(`PRG_FIFO_DEPTH),
      .AW(`PRG_FIFO_AW)
   ) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_nrst(i_nrst),
      .i_flush(fifo_flush),
      .i_in_valid(hold && gate_now),
      .o_in_ready(fifo_in_ready),
      .i_in_data(word),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_out_data),
      .o_count(fifo_count)
   );

   // Generator state
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
         state <= ST_IDLE;
      else if (!enable)
         state <= ST_IDLE;
      else
      begin
         case (state)
            ST_IDLE:
               state <= ST_START;
            ST_START:
               if (any_fail)
                  state <= ST_FAIL; // RULE_02
               else if (win_end)
                  state <= ST_RUN; // RULE_05
            ST_RUN:
               if (any_fail)
                  state <= ST_FAIL; // RULE_06
            ST_FAIL:
               if (restart && !(fl_total || fl_online || fl_cont) )
                  state <= ST_START;
            default:
               state <= ST_IDLE;
         endcase
      end
   end

   // Sticky failure flags; a new event wins over a restart in the same cycle
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         fl_total <= 1'b0;
         fl_online <= 1'b0;
         fl_cont <= 1'b0;
      end
      else
      begin
         fl_total <= total_ev || (fl_total && !restart); // RULE_01
         fl_online <= online_ev || (fl_online && !restart); // RULE_06
         fl_cont <= cont_ev || (fl_cont && !restart); // RULE_14
      end
   end

   // Health test counters run on every raw bit in the start and run states, requested or not
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst || !active)
      begin
         last_bit <= 1'b0;
         run_len <= 6'h00;
         win_cnt <= 10'h000;
         ones <= 11'h000;
      end
      else
      begin
         last_bit <= i_raw_bit;
         if (i_raw_bit == last_bit && run_len != 6'h00)
            run_len <= run_len + 6'h01;
         else
            run_len <= 6'h01;
         win_cnt <= win_cnt + 10'h001; // RULE_07
         ones <= win_end ? 11'h000 : ones_next;
      end
   end

   // Word assembly; a held word stalls assembly until the buffer takes it or the gate is shut
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst || !active || any_fail)
      begin
         shreg <= 16'h0000;
         bit_cnt <= 5'h00;
         hold <= 1'b0;
         word <= 16'h0000;
      end
      else if (hold)
      begin
         if (!gate_now || fifo_in_ready)
            hold <= 1'b0;
      end
      else if (blk_done)
      begin
         word <= blk_next;
         hold <= 1'b1;
         bit_cnt <= 5'h00;
         shreg <= 16'h0000;
      end
      else
      begin
         shreg <= {shreg[14:0], i_raw_bit}; // RULE_09 RULE_10
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // Previous block for the continuous comparison
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst || !active)
      begin
         prev_block <= 16'h0000;
         prev_valid <= 1'b0;
      end
      else if (blk_done)
      begin
         prev_block <= blk_next; // RULE_11
         prev_valid <= 1'b1;
      end
   end

   // Control register
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
         ctrl <= `PRG_CTRL_RESET;
      else if (apb_done && i_pwrite && i_paddr == `PRG_ADDR_CTRL)
         ctrl <= i_pwdata[3:0]; // RULE_12
   end

   // APB slave: one wait-free access cycle, read data latched at setup
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
         rd_ok <= 1'b0;
      end
      else
      begin
         o_pready <= apb_setup;
         if (apb_setup)
         begin
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
            rd_ok <= 1'b0;
            case (i_paddr)
               `PRG_ADDR_CTRL:
                  if (!i_pwrite)
                     o_prdata <= {28'h0000000, ctrl};
               `PRG_ADDR_STATUS:
                  if (i_pwrite)
                     o_pslverr <= 1'b1;
                  else
                     o_prdata <= {18'h00000, fifo_count, 2'b00, state, fl_cont,
                        fl_online, fl_total, o_gate_open};
               `PRG_ADDR_DATA:
                  if (i_pwrite || !fifo_out_valid || !gate_now)
                     o_pslverr <= 1'b1; // RULE_02 RULE_06
                  else
                  begin
                     o_prdata <= {16'h0000, fifo_out_data};
                     rd_ok <= 1'b1;
                  end
               default:
                  o_pslverr <= 1'b1;
            endcase
         end
      end
   end

   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
         o_gate_open <= 1'b0;
      else
         o_gate_open <= gate_now;
   end
endmodule // prg_health_gate

// file: test/prg_src_model.sv
// Behavioural entropy source that feeds the raw bit input.
// Assumes the bench picks a mode; bits change right after each rising edge.
`timescale 1ns/100ps
module prg_src_model (
   input wire i_clk_sys,
   input wire [1:0] i_mode,
   output reg o_raw_bit
);
   localparam [8:0] PAT = 9'h0B5;
   integer seed;
   reg [3:0] ph;
   initial
   begin
      seed = 32168;
      ph = 4'h0;
      o_raw_bit = 1'b0;
   end
   // Modes: 0 fair, 1 stuck high, 2 seven ones in nine, 3 nine-bit pattern
   // Nine-bit period matches one byte block plus its hand-over cycle, so
   // byte blocks repeat exactly, while runs stay short and the ones count fair
   always @(posedge i_clk_sys)
   begin
      ph <= (ph == 4'h8) ? 4'h0 : ph + 4'h1;
      case (i_mode)
         2'h0: o_raw_bit <= $random(seed);
         2'h1: o_raw_bit <= 1'b1;
         2'h2: o_raw_bit <= (ph[1:0] != 2'h3);
         default: o_raw_bit <= PAT[ph];
      endcase
   end
endmodule // prg_src_model

// file: test/prg_health_gate_properties.sv
// Port-level checker for the random generator's bus and output gate.
// Assumes it is bound to prg_health_gate and sees only its ports.
`timescale 1ns/100ps
module prg_health_props (
   input wire i_clk_sys,
   input wire i_nrst,
   input wire i_raw_bit,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   input wire [31:0] o_prdata,
   input wire o_pready,
   input wire o_pslverr,
   input wire o_gate_open
);
   reg [5:0] run_cnt;
   reg [10:0] up_cnt;
   reg last_bit;
   wire setup = i_psel && !i_penable;
   // Length of the current run of equal raw bits, and time since reset
   always @(posedge i_clk_sys)
   begin
      if (!i_nrst)
      begin
         run_cnt <= 6'h0;
         up_cnt <= 11'h0;
         last_bit <= 1'b0;
      end
      else
      begin
         last_bit <= i_raw_bit;
         if (i_raw_bit != last_bit)
            run_cnt <= 6'h01;
         else if (run_cnt != 6'h3F)
            run_cnt <= run_cnt + 6'h01;
         up_cnt <= (up_cnt == 11'h7FF) ? up_cnt : up_cnt + 11'h1;
      end
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_nrst);
   pready_after_setup_a: assert property (setup |=> o_pready) else $error("no ready");
   pready_single_a: assert property (o_pready |=> !o_pready) else $error("ready too long");
   unmapped_err_a: assert property (setup && i_paddr > 12'h008 |=> o_pslverr && o_prdata == 32'h0)
      else $error("unmapped access accepted");
   ro_write_err_a: assert property (setup && i_pwrite && (i_paddr == 12'h004 || i_paddr == 12'h008)
      |=> o_pslverr) else $error("read-only write accepted");
   closed_read_err_a: assert property (
      setup && !i_pwrite && i_paddr == 12'h008 && !o_gate_open
      |=> o_pslverr && o_prdata == 32'h0) else $error("word given while gate closed");
   word_width_a: assert property (o_pready && !o_pslverr && i_paddr == 12'h008
      |-> o_prdata[31:16] == 16'h0) else $error("word wider than sixteen bits");
   stuck_closes_a: assert property (run_cnt >= 6'h23 |-> !o_gate_open)
      else $error("gate open on stuck source");
   startup_wait_a: assert property ($rose(o_gate_open) |-> up_cnt >= 11'h400)
      else $error("gate opened before start-up window");
   cover property (o_gate_open);
   cover property (run_cnt == 6'h23);
   cover property (o_pready && !o_pslverr && i_paddr == 12'h008);
endmodule // prg_health_props
bind prg_health_gate prg_health_props prg_health_props_inst (.i_clk_sys(i_clk_sys),
   .i_nrst(i_nrst), .i_raw_bit(i_raw_bit), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_gate_open(o_gate_open));

// file: test/tb.sv
// Self-checking bench for the random generator with health gate.
// Assumes the source model and the bound checker are compiled beside it.
`timescale 1ns/100ps
module tb;
   reg i_clk_sys, i_nrst, i_psel, i_penable, i_pwrite, e;
   reg [11:0] i_paddr;
   reg [31:0] i_pwdata, q, r;
   reg [1:0] mode;
   wire raw_bit, o_pready, o_pslverr, o_gate_open;
   wire [31:0] o_prdata;
   integer bad_count, check_count, seed, n, i;
   prg_health_gate prg_health_gate_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
      .i_raw_bit(raw_bit), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
      .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
      .o_pslverr(o_pslverr), .o_gate_open(o_gate_open));
   prg_src_model prg_src_model_inst (.i_clk_sys(i_clk_sys), .i_mode(mode), .o_raw_bit(raw_bit));
   function [31:0] stx(input [1:0] s, input [2:0] f, input g);
      stx = {26'h0, s, f, g};
   endfunction
   task give_verdict;
      begin
         $display("mismatches %0d checks %0d", bad_count, check_count);
         if (bad_count == 0 && check_count > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   task chk(input [127:0] nm, input [31:0] x, input [31:0] g);
      begin
         check_count = check_count + 1;
         if (g !== x)
         begin
            $display("BAD %0s exp %h got %h", nm, x, g);
            bad_count = bad_count + 1;
         end
      end
   endtask
   // One APB transfer, then one idle cycle
   task apb(input w, input [11:0] a, input [31:0] d);
      integer k;
      begin
         i_psel <= 1'b1;
         i_pwrite <= w;
         i_paddr <= a;
         i_pwdata <= d;
         @(posedge i_clk_sys);
         i_penable <= 1'b1;
         k = 0;
         do
         begin
            @(posedge i_clk_sys);
            k = k + 1;
         end
         while (o_pready !== 1'b1 && k < 20);
         q = o_prdata;
         e = o_pslverr;
         i_psel <= 1'b0;
         i_penable <= 1'b0;
         if (k >= 20)
         begin
            chk("pready", 1, 0);
            give_verdict;
         end
         @(posedge i_clk_sys);
      end
   endtask
   task wait_gate(input lvl, input integer lim);
      begin
         n = 0;
         while (o_gate_open !== lvl && n < lim)
         begin
            @(posedge i_clk_sys);
            n = n + 1;
         end
         if (n >= lim)
         begin
            chk("gate_wait", lvl, ~lvl);
            give_verdict;
         end
      end
   endtask
   initial
   begin
      i_clk_sys = 1'b0;
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   initial
   begin
      {i_nrst, i_psel, i_penable, i_pwrite, e} = 5'h00;
      i_paddr = 12'h000;
      i_pwdata = 32'h0;
      mode = 2'h0;
      bad_count = 0;
      check_count = 0;
      seed = 32168;
      repeat (5) @(posedge i_clk_sys);
      i_nrst <= 1'b1;
      @(posedge i_clk_sys);
      apb(0, 12'h004, 0);
      chk("status_rst", stx(0, 0, 0), q);
      r = $random(seed) & 32'h0E;
      apb(1, 12'h000, r);
      apb(0, 12'h000, 0);
      chk("ctrl", r, q);
      apb(0, 12'h00C, 0);
      chk("unmapped_err", 1, e);
      apb(1, 12'h004, $random(seed));
      chk("ro_err", 1, e);
      apb(1, 12'h000, 32'h03);
      apb(0, 12'h008, 0);
      chk("early_err", 1, e);
      wait_gate(1, 1200);
      chk("startup_len", 1, n >= 1000);
      // One word per seventeen cycles: let at least four words gather
      repeat (100) @(posedge i_clk_sys);
      for (i = 0; i < 4; i = i + 1)
      begin
         apb(0, 12'h008, 0);
         chk("rd_err", 0, e);
         chk("rd_hi", 0, q >> 16);
      end
      apb(0, 12'h004, 0);
      chk("run_st", stx(2, 0, 1), q & 32'h3F);
      mode <= 2'h1;
      wait_gate(0, 40);
      chk("stuck_time", 1, n <= 36);
      apb(0, 12'h008, 0);
      chk("stuck_rd", 1, e);
      apb(0, 12'h004, 0);
      chk("stuck_st", stx(3, 1, 0), q & 32'h3F33);
      mode <= 2'h0;
      apb(1, 12'h000, 32'h13);
      apb(1, 12'h000, 32'h13);
      wait_gate(1, 1200);
      mode <= 2'h2;
      wait_gate(0, 2100);
      apb(0, 12'h004, 0);
      chk("online_st", stx(3, 2, 0), q & 32'h3F35);
      mode <= 2'h3;
      apb(1, 12'h000, 32'h11);
      apb(1, 12'h000, 32'h11);
      repeat (40) @(posedge i_clk_sys);
      apb(0, 12'h004, 0);
      chk("cont_st", stx(3, 4, 0), q & 32'h3F39);
      // Hybrid class: running but unseeded keeps the gate shut
      mode <= 2'h0;
      apb(1, 12'h000, 32'h17);
      apb(1, 12'h000, 32'h17);
      repeat (1100) @(posedge i_clk_sys);
      apb(0, 12'h004, 0);
      chk("hyb_wait", stx(2, 0, 0), q & 32'h3F);
      apb(0, 12'h008, 0);
      chk("hyb_rd_err", 1, e);
      apb(1, 12'h000, 32'h0F);
      wait_gate(1, 10);
      repeat (20) @(posedge i_clk_sys);
      apb(0, 12'h008, 0);
      chk("hyb_rd", 0, e);
      give_verdict;
   end
endmodule // tb
